// [ccx_pkg.sv]
// Purpose: constants for the clear and call execution block
// Assumes: 14-bit instruction words, 13-bit program counter
// Notes: register offsets are byte addresses on the apb bus
package ccx_pkg;
   // ***********************
   // instruction encodings
   // ***********************
   localparam logic [13:0] ccx_full_mask = 14'h3FFF;
   localparam logic [13:0] ccx_clear_file_mask = 14'h3F80;
   localparam logic [13:0] ccx_clear_file_code = 14'h0180;
   localparam logic [13:0] ccx_clear_working_code = 14'h0103;
   localparam logic [13:0] ccx_clear_watchdog_code = 14'h0064;
   localparam logic [13:0] ccx_call_mask = 14'h3800;
   localparam logic [13:0] ccx_call_code = 14'h2000;
   // ***********************
   // apb register offsets
   // ***********************
   localparam logic [7:0] ccx_instr_off = 8'h00;
   localparam logic [7:0] ccx_latch_off = 8'h04;
   localparam logic [7:0] ccx_pc_off = 8'h08;
   localparam logic [7:0] ccx_wreg_off = 8'h0C;
   localparam logic [7:0] ccx_status_off = 8'h10;
   localparam logic [7:0] ccx_stack_top_off = 8'h14;
   localparam logic [7:0] ccx_watchdog_off = 8'h18;
   localparam logic [7:0] ccx_file_off = 8'h80;
   // ***********************
   // status bits and sizes
   // ***********************
   localparam int ccx_z_bit = 2;
   localparam int ccx_powerdown_bit = 3;
   localparam int ccx_timeout_bit = 4;
   localparam int ccx_file_words = 128;
   localparam int ccx_stack_depth = 8;
   localparam logic [7:0] ccx_status_rst = 8'h18;
   localparam logic [12:0] ccx_pc_rst = 13'h0000;
endpackage

// [ccx_core.sv]
// Purpose: executes clear file, clear w, clear watchdog and call
// Assumes: one pclk edge per instruction cycle; apb register access
// Notes: an instruction is issued by writing its word to the instr reg
//
// Behaviour
// - clear file clears register, sets zero flag
// - call pushes pc plus one onto stack
// - call loads 11-bit immediate into pc low
// - call takes pc 12:11 from latch 4:3
// - call takes two cycles, flags unchanged
// - clear w zeroes working register, sets zero
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ccx_core (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // execution state
   output logic busy,
   output logic [12:0] pc
);
   typedef enum logic [1:0] {ccx_idle, ccx_call2} ccx_state_e;

   // ***********************
   // storage
   // ***********************
   logic [7:0] file_mem [ccx_pkg::ccx_file_words];
   // stack wraps at eight entries
   logic [12:0] stack_mem [ccx_pkg::ccx_stack_depth];
   logic [2:0] sp_reg;
   ccx_state_e state_reg;
   logic [13:0] instr_reg;
   logic [7:0] pc_high_latch;
   logic [12:0] pc_reg;
   logic [7:0] w_reg;
   logic [7:0] status_reg;
   logic [7:0] watchdog_counter;
   logic [7:0] prescale_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;

   // ***********************
   // decode
   // ***********************
   function automatic logic is_op(input logic [13:0] w,
                                  input logic [13:0] m,
                                  input logic [13:0] c);
      is_op = (w & m) == c;
   endfunction

   wire logic setup = psel && !penable;
   wire logic wr = setup && pwrite;
   wire logic rd = setup && !pwrite;
   wire logic file_hit = paddr[7] && (paddr[1:0] == 2'b00);
   wire logic [6:0] file_idx = paddr[6:0] >> 2;
   wire logic issue = wr && (paddr == ccx_pkg::ccx_instr_off) &&
      (state_reg == ccx_idle);
   wire logic [13:0] op = pwdata[13:0];
   wire logic clear_file_register_op = issue &&
      is_op(op, ccx_pkg::ccx_clear_file_mask, ccx_pkg::ccx_clear_file_code);
   wire logic clear_working_op = issue &&
      is_op(op, ccx_pkg::ccx_full_mask, ccx_pkg::ccx_clear_working_code);
   wire logic clear_watchdog_op = issue &&
      is_op(op, ccx_pkg::ccx_full_mask, ccx_pkg::ccx_clear_watchdog_code);
   wire logic call_op = issue &&
      is_op(op, ccx_pkg::ccx_call_mask, ccx_pkg::ccx_call_code);
   // target built in the second call cycle from the latched word
   wire logic [12:0] call_target =
      {pc_high_latch[4:3], instr_reg[10:0]};
   wire logic known_addr = file_hit ||
      paddr == ccx_pkg::ccx_instr_off || paddr == ccx_pkg::ccx_latch_off ||
      paddr == ccx_pkg::ccx_pc_off || paddr == ccx_pkg::ccx_wreg_off ||
      paddr == ccx_pkg::ccx_status_off ||
      paddr == ccx_pkg::ccx_stack_top_off ||
      paddr == ccx_pkg::ccx_watchdog_off;

   // ***********************
   // register write decode
   // ***********************
   wire logic wr_latch = wr && (paddr == ccx_pkg::ccx_latch_off);
   wire logic wr_w = wr && (paddr == ccx_pkg::ccx_wreg_off);
   wire logic wr_status = wr && (paddr == ccx_pkg::ccx_status_off);
   wire logic wr_file = wr && file_hit;
   wire logic [2:0] tos_idx = sp_reg - 3'h1;
   wire logic [31:0] rd_mux =
      file_hit ? {24'h000000, file_mem[file_idx]} :
      paddr == ccx_pkg::ccx_instr_off ? {18'h00000, instr_reg} :
      paddr == ccx_pkg::ccx_latch_off ? {24'h000000, pc_high_latch} :
      paddr == ccx_pkg::ccx_pc_off ? {19'h00000, pc_reg} :
      paddr == ccx_pkg::ccx_wreg_off ? {24'h000000, w_reg} :
      paddr == ccx_pkg::ccx_status_off ? {24'h000000, status_reg} :
      paddr == ccx_pkg::ccx_stack_top_off ?
         {19'h00000, stack_mem[tos_idx]} :
      paddr == ccx_pkg::ccx_watchdog_off ?
         {24'h000000, watchdog_counter} :
      32'h00000000;

   // ***********************
   // apb answer, no wait state
   // ***********************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup && !known_addr;
         prdata_reg <= rd ? rd_mux : 32'h00000000;
      end
   end

   // ***********************
   // watchdog counter and prescaler
   // ***********************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_counter <= 8'h00;
         prescale_reg <= 8'h00;
      end else if (clear_watchdog_op) begin
         watchdog_counter <= 8'h00;
         prescale_reg <= 8'h00;
      end else begin
         watchdog_counter <= watchdog_counter + {7'h00, &prescale_reg};
         prescale_reg <= prescale_reg + 8'h01;
      end
   end

   // ***********************
   // execution
   // ***********************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ccx_idle;
         instr_reg <= 14'h0000;
         pc_high_latch <= 8'h00;
         pc_reg <= ccx_pkg::ccx_pc_rst;
         w_reg <= 8'h00;
         status_reg <= ccx_pkg::ccx_status_rst;
         sp_reg <= 3'h0;
      end else begin
         if (issue) begin
            instr_reg <= op;
         end
         if (wr_latch) begin
            pc_high_latch <= pwdata[7:0];
         end
         if (wr_w) begin
            w_reg <= pwdata[7:0];
         end
         if (wr_status) begin
            status_reg <= pwdata[7:0];
         end
         // flag set by an instruction wins over a bus status write
         unique case (state_reg)
            ccx_idle: begin
               if (issue && !call_op) begin
                  pc_reg <= pc_reg + 13'h0001;
               end
               if (clear_file_register_op || clear_working_op) begin
                  status_reg[ccx_pkg::ccx_z_bit] <= 1'b1;
               end
               if (clear_working_op) begin
                  w_reg <= 8'h00;
               end
               if (clear_watchdog_op) begin
                  status_reg[ccx_pkg::ccx_timeout_bit] <= 1'b1;
                  status_reg[ccx_pkg::ccx_powerdown_bit] <= 1'b1;
               end
               if (call_op) begin
                  state_reg <= ccx_call2;
                  sp_reg <= sp_reg + 3'h1;
               end
            end
            ccx_call2: begin
               pc_reg <= call_target;
               state_reg <= ccx_idle;
            end
            default: begin
               state_reg <= ccx_idle;
            end
         endcase
      end
   end

   // file and stack memories, no reset
   always_ff @(posedge pclk) begin
      if (wr_file) begin
         file_mem[file_idx] <= pwdata[7:0];
      end
      if (clear_file_register_op) begin
         file_mem[op[6:0]] <= 8'h00;
      end
      if (call_op) begin
         stack_mem[sp_reg] <= pc_reg + 13'h0001;
      end
   end

   // ***********************
   // outputs
   // ***********************
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign pc = pc_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
      end else begin
         busy <= call_op;
      end
   end
endmodule
`default_nettype wire

// [ccx_chk.sv]
// Purpose: port assertions for ccx_core
// Assumes: one wait-free apb access, call busy in its second cycle
// Notes: latch copy kept in helper logic
`timescale 1ns/1ns
`default_nettype none
module ccx_chk (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // execution
   input wire logic busy,
   input wire logic [12:0] pc
);
   logic [1:0] lat_reg;
   wire setup = psel && !penable;
   wire iss = setup && pwrite && paddr == ccx_pkg::ccx_instr_off && !busy;
   wire [13:0] op = pwdata[13:0];
   wire call = iss && (op & ccx_pkg::ccx_call_mask) == ccx_pkg::ccx_call_code;
   wire clr = iss && (op == ccx_pkg::ccx_clear_working_code ||
      op == ccx_pkg::ccx_clear_watchdog_code ||
      (op & ccx_pkg::ccx_clear_file_mask) == ccx_pkg::ccx_clear_file_code);
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) lat_reg <= 2'h0;
      else if (setup && pwrite && paddr == ccx_pkg::ccx_latch_off)
         lat_reg <= pwdata[4:3];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence call_seq;
      call ##1 busy;
   endsequence
   chk_call_busy: assert property (call |=> busy ##1 !busy)
      else $error("call busy span wrong");
   chk_busy_cause: assert property ($rose(busy) |-> $past(call))
      else $error("busy without call");
   chk_call_target: assert property (call_seq |=>
      pc[10:0] == $past(pwdata[10:0], 2)) else $error("call target wrong");
   chk_call_page: assert property (call_seq |=>
      pc[12:11] == $past(lat_reg, 2)) else $error("call page wrong");
   chk_clr_step: assert property (clr |=>
      pc == $past(pc) + 13'h1 && !busy) else $error("clear not one cycle");
   chk_ready_next: assert property (setup |=> pready)
      else $error("no answer after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready too long");
   chk_err_map: assert property (setup && paddr == 8'h40 |=> pslverr)
      else $error("unmapped without error");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule
bind ccx_core ccx_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .pc(pc));
`default_nettype wire

// [clear_and_call_execution_tb.sv]
// Purpose: self-checking bench for ccx_core
// Assumes: reads queue expectations, a monitor compares them
// Notes: random data from a 16-bit lfsr
`timescale 1ns/1ns
`default_nettype none
module clear_and_call_execution_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, busy;
   logic [12:0] pc, pc_m;
   logic [15:0] lfsr = 16'h8620;
   logic [32:0] exp_q[$], mon_e;
   int bad_count = 0, cmp_count = 0;
   always #10 pclk = ~pclk;
   ccx_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
      .pc(pc));
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input string n, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tally_and_finish();
      if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [32:0] e);
      int n;
      @(posedge pclk);
      if (!w) exp_q.push_back(e);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      @(negedge pclk);
      while (!pready && n < 20) begin
         @(negedge pclk);
         n++;
      end
      if (n >= 20) begin
         bad_count++;
         tally_and_finish();
      end
      @(posedge pclk);
      psel <= 0;
      penable <= 0;
   endtask
   task automatic ins(input logic [13:0] op);
      apb(1, ccx_pkg::ccx_instr_off, {18'h0, op}, 33'h0);
   endtask
   always @(negedge pclk)
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
         mon_e = exp_q.pop_front();
         check("pslverr", {31'h0, pslverr}, {31'h0, mon_e[32]});
         if (!mon_e[32]) check("prdata", prdata, mon_e[31:0]);
      end
   initial begin
      fork
         begin
            #100000 bad_count++;
            tally_and_finish();
         end
      join_none
      repeat (5) @(posedge pclk);
      presetn <= 1;
      pc_m = ccx_pkg::ccx_pc_rst;
      apb(0, ccx_pkg::ccx_status_off, 0, {25'h0, ccx_pkg::ccx_status_rst});
      apb(0, ccx_pkg::ccx_pc_off, 0, {20'h0, pc_m});
      apb(0, 8'h40, 0, 33'h1_0000_0000);
      for (int i = 0; i < 3; i++) begin
         lfsr = nxt(lfsr);
         apb(1, 8'h80 + {1'b0, lfsr[4:0], 2'b00}, {24'h0, lfsr[15:8]}, 0);
         apb(1, ccx_pkg::ccx_wreg_off, {24'h0, lfsr[7:0]}, 0);
         apb(1, ccx_pkg::ccx_status_off, 0, 0);
         ins(ccx_pkg::ccx_clear_file_code | {9'h0, lfsr[4:0]});
         ins(ccx_pkg::ccx_clear_working_code);
         pc_m += 13'h2;
         apb(0, 8'h80 + {1'b0, lfsr[4:0], 2'b00}, 0, 0);
         apb(0, ccx_pkg::ccx_wreg_off, 0, 0);
         apb(0, ccx_pkg::ccx_status_off, 0, 33'h4);
      end
      apb(1, ccx_pkg::ccx_status_off, 0, 0);
      repeat (600) @(posedge pclk);
      ins(ccx_pkg::ccx_clear_watchdog_code);
      pc_m += 13'h1;
      apb(0, ccx_pkg::ccx_watchdog_off, 0, 0);
      for (int i = 0; i < 4; i++) begin
         apb(0, ccx_pkg::ccx_status_off, 0, {25'h0, 8'h18});
         lfsr = nxt(lfsr);
         apb(1, ccx_pkg::ccx_latch_off, {24'h0, lfsr[15:8]}, 0);
         ins(ccx_pkg::ccx_call_code | {3'h0, lfsr[10:0]});
         apb(0, ccx_pkg::ccx_stack_top_off, 0,
            {20'h0, pc_m + 13'h1});
         pc_m = {lfsr[12:11], lfsr[10:0]};
         apb(0, ccx_pkg::ccx_pc_off, 0, {20'h0, pc_m});
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
